// >>> design/sac_control.sv
// Register file and conversion sequencer of the converter control block
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sac_control (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sac_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [sac_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [sac_pkg::DATA_W-1:0] wb_dat_i,
  output logic [sac_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // System
  input wire logic stop_i,
  output logic irq_o,
  // Analog converter side
  input wire logic oscillator_clock_i,
  input wire logic [sac_pkg::RESULT_W-1:0] conv_result_i,
  output logic [4:0] channel_select_o,
  output logic high_reference_o,
  output logic low_reference_o,
  output logic power_down_o,
  output logic converting_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [sac_pkg::TICK_W-1:0] div_last(
    input logic [2:0] code
  );
    logic [sac_pkg::TICK_W-1:0] r;
    r = sac_pkg::DIV16_LAST;
    case (code)
      3'h0: r = sac_pkg::DIV1_LAST;
      3'h1: r = sac_pkg::DIV2_LAST;
      3'h2: r = sac_pkg::DIV4_LAST;
      3'h3: r = sac_pkg::DIV8_LAST;
      default: r = sac_pkg::DIV16_LAST;
    endcase
    return r;
  endfunction : div_last

  function automatic logic [7:0] format_byte(
    input logic [sac_pkg::RESULT_W-1:0] raw,
    input logic [1:0] mode,
    input logic high
  );
    logic [7:0] r;
    r = 8'h00;
    case (mode)
      sac_pkg::JUSTIFY_TRUNC8: r = high ? 8'h00 : raw[9:2];
      sac_pkg::JUSTIFY_RIGHT: r = high ? {6'h00, raw[9:8]} : raw[7:0];
      sac_pkg::JUSTIFY_LEFT: r = high ? raw[9:2] : {raw[1:0], 6'h00};
      sac_pkg::JUSTIFY_LEFT_SIGNED: begin
        r = high ? {~raw[9], raw[8:2]} : {raw[1:0], 6'h00};
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction : format_byte

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sac_pkg::sac_status_control_t status_control;
  sac_pkg::sac_clock_config_t clock_config;
  sac_pkg::sac_state_t state;
  logic [sac_pkg::TICK_W-1:0] tick_count;
  logic [sac_pkg::TICK_W-1:0] div_count;
  logic resume_pending;
  logic result_lock;
  logic [sac_pkg::RESULT_W-1:0] result;
  logic [sac_pkg::RESULT_W-1:0] result_s1;
  logic [sac_pkg::RESULT_W-1:0] result_s2;
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic bus_req;
  logic write_control;
  logic write_clock;
  logic read_high;
  logic read_low;
  logic result_read;
  logic truncating;
  logic powered;
  logic next_powered;
  logic source_tick;
  logic conv_tick;
  logic conv_done;
  logic store_result;
  logic [7:0] read_byte;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign write_control = bus_req & wb_we_i & wb_sel_i[sac_pkg::LANE_LOW]
    & (wb_adr_i == sac_pkg::OFS_STATUS_CONTROL);
  assign write_clock = bus_req & wb_we_i & wb_sel_i[sac_pkg::LANE_LOW]
    & (wb_adr_i == sac_pkg::OFS_CLOCK_CONFIG);
  assign read_high = bus_req & ~wb_we_i
    & (wb_adr_i == sac_pkg::OFS_RESULT_HIGH);
  assign read_low = bus_req & ~wb_we_i
    & (wb_adr_i == sac_pkg::OFS_RESULT_LOW);
  assign result_read = read_high | read_low;
  assign truncating = {clock_config.justify_sel_hi,
    clock_config.justify_sel_lo} == sac_pkg::JUSTIFY_TRUNC8;
  assign powered = status_control.channel_select != sac_pkg::CHANNEL_POWER_OFF;
  assign next_powered = wb_dat_i[4:0] != sac_pkg::CHANNEL_POWER_OFF;

  always_comb begin
    read_byte = 8'h00;
    case (wb_adr_i)
      sac_pkg::OFS_STATUS_CONTROL: begin
        read_byte = status_control;
        read_byte[7] = status_control.conv_complete_flag
          & ~status_control.conv_irq_enable;
      end
      sac_pkg::OFS_RESULT_HIGH: begin
        read_byte = format_byte(result, {clock_config.justify_sel_hi,
          clock_config.justify_sel_lo}, 1'b1);
      end
      sac_pkg::OFS_RESULT_LOW: begin
        read_byte = format_byte(result, {clock_config.justify_sel_hi,
          clock_config.justify_sel_lo}, 1'b0);
      end
      sac_pkg::OFS_CLOCK_CONFIG: read_byte = clock_config;
      default: read_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= {{(sac_pkg::DATA_W-8){1'b0}}, read_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_control <= sac_pkg::STATUS_CONTROL_RESET;
    end else if (ce_i) begin
      if (write_control) begin
        status_control.conv_irq_enable <= wb_dat_i[6];
        status_control.continuous_conv <= wb_dat_i[5];
        status_control.channel_select <= wb_dat_i[4:0];
      end
      status_control.conv_complete_flag <=
        (conv_done & ~status_control.conv_irq_enable)
        | (status_control.conv_complete_flag & ~result_read
        & ~status_control.conv_irq_enable);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_config <= sac_pkg::CLOCK_CONFIG_RESET;
    end else if (ce_i && write_clock) begin
      clock_config <= {wb_dat_i[7:2], 2'h0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= (conv_done & status_control.conv_irq_enable)
        | (irq_o & ~result_read & ~write_control);
    end
  end

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else if (ce_i) begin
      osc_s1 <= oscillator_clock_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  assign source_tick = (clock_config.clock_source_select
    == sac_pkg::CLOCK_SOURCE_BUS) | (osc_s2 & ~osc_s3);
  assign conv_tick = source_tick
    & (div_count >= div_last(clock_config.clock_prescaler));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_count <= '0;
    end else if (ce_i && (write_control || stop_i
        || state == sac_pkg::SAC_HALT)) begin
      div_count <= '0;
    end else if (ce_i && source_tick) begin
      div_count <= conv_tick ? '0 : div_count + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // sixteenth tick ends it
  assign conv_done = (state == sac_pkg::SAC_CONVERT) & conv_tick
    & (tick_count == sac_pkg::CONV_LAST_TICK) & ~stop_i & ~write_control
    & powered;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sac_pkg::SAC_IDLE;
      tick_count <= '0;
      resume_pending <= 1'b0;
    end else if (ce_i) begin
      if (stop_i) begin
        resume_pending <= resume_pending
          | (state == sac_pkg::SAC_CONVERT) | write_control;
        state <= sac_pkg::SAC_HALT;
        tick_count <= '0;
      end else if (write_control) begin
        state <= next_powered ? sac_pkg::SAC_CONVERT : sac_pkg::SAC_IDLE;
        tick_count <= '0;
      end else begin
        case (state)
          sac_pkg::SAC_HALT: begin
            state <= (resume_pending && powered) ?
              sac_pkg::SAC_CONVERT : sac_pkg::SAC_IDLE;
            resume_pending <= 1'b0;
            tick_count <= '0;
          end
          sac_pkg::SAC_CONVERT: begin
            if (!powered) begin
              state <= sac_pkg::SAC_IDLE;
            end else if (conv_tick) begin
              if (tick_count == sac_pkg::CONV_LAST_TICK) begin
                tick_count <= '0;
                state <= status_control.continuous_conv ?
                  sac_pkg::SAC_CONVERT : sac_pkg::SAC_IDLE;
              end else begin
                tick_count <= tick_count + 1'b1;
              end
            end
          end
          default: begin
            state <= sac_pkg::SAC_IDLE;
            tick_count <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Result capture and interlock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_s1 <= '0;
      result_s2 <= '0;
    end else if (ce_i) begin
      result_s1 <= conv_result_i;
      result_s2 <= result_s1;
    end
  end

  assign store_result = conv_done & (truncating
    | ((~result_lock | read_low) & ~read_high));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_lock <= 1'b0;
    end else if (ce_i) begin
      if (truncating || read_low) begin
        result_lock <= 1'b0;
      end else if (read_high) begin
        result_lock <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= '0;
    end else if (ce_i && store_result) begin
      result <= result_s2;
    end
  end

  // ----------------------------------------------------------------
  // Analog side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_select_o <= sac_pkg::STATUS_CONTROL_RESET.channel_select;
      high_reference_o <= 1'b0;
      low_reference_o <= 1'b0;
      power_down_o <= 1'b1;
      converting_o <= 1'b0;
    end else if (ce_i) begin
      channel_select_o <= status_control.channel_select;
      high_reference_o <= status_control.channel_select
        == sac_pkg::CHANNEL_HIGH_REFERENCE;
      low_reference_o <= status_control.channel_select
        == sac_pkg::CHANNEL_LOW_REFERENCE;
      power_down_o <= ~powered | (state == sac_pkg::SAC_HALT);
      converting_o <= state == sac_pkg::SAC_CONVERT;
    end
  end

endmodule : sac_control

`default_nettype wire

// >>> include/sac_pkg.sv
// Shared constants and types of the converter control block
package sac_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_CONFIG = 4'hC;
  localparam int unsigned LANE_LOW = 0;

  // ----------------------------------------------------------------
  // Register layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic conv_complete_flag;
    logic conv_irq_enable;
    logic continuous_conv;
    logic [4:0] channel_select;
  } sac_status_control_t;

  typedef struct packed {
    logic [2:0] clock_prescaler;
    logic clock_source_select;
    logic justify_sel_hi;
    logic justify_sel_lo;
    logic [1:0] reserved;
  } sac_clock_config_t;

  localparam sac_status_control_t STATUS_CONTROL_RESET = 8'h1F;
  localparam sac_clock_config_t CLOCK_CONFIG_RESET = 8'h04;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] JUSTIFY_TRUNC8 = 2'h0;
  localparam logic [1:0] JUSTIFY_RIGHT = 2'h1;
  localparam logic [1:0] JUSTIFY_LEFT = 2'h2;
  localparam logic [1:0] JUSTIFY_LEFT_SIGNED = 2'h3;

  localparam logic [4:0] CHANNEL_HIGH_REFERENCE = 5'h1D;
  localparam logic [4:0] CHANNEL_LOW_REFERENCE = 5'h1E;
  localparam logic [4:0] CHANNEL_POWER_OFF = 5'h1F;

  localparam logic CLOCK_SOURCE_BUS = 1'h1;

  localparam int unsigned RESULT_W = 10;
  localparam int unsigned TICK_W = 4;
  localparam logic [TICK_W-1:0] CONV_LAST_TICK = 4'hF;
  localparam logic [TICK_W-1:0] DIV1_LAST = 4'h0;
  localparam logic [TICK_W-1:0] DIV2_LAST = 4'h1;
  localparam logic [TICK_W-1:0] DIV4_LAST = 4'h3;
  localparam logic [TICK_W-1:0] DIV8_LAST = 4'h7;
  localparam logic [TICK_W-1:0] DIV16_LAST = 4'hF;

  // ----------------------------------------------------------------
  // Conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_CONVERT = 2'h1,
    SAC_HALT = 2'h3
  } sac_state_t;

endpackage : sac_pkg

// >>> sim/sac_control_sva.sv
// Port checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_control_sva (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sac_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [sac_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [sac_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // System and converter side
  input wire logic stop_i,
  input wire logic irq_o,
  input wire logic [4:0] channel_select_o,
  input wire logic high_reference_o,
  input wire logic low_reference_o,
  input wire logic power_down_o,
  input wire logic converting_o
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  logic take;
  logic ctl_wr;
  logic off;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign ctl_wr = take && wb_we_i && wb_sel_i[0]
    && wb_adr_i == sac_pkg::OFS_STATUS_CONTROL;
  assign off = channel_select_o == sac_pkg::CHANNEL_POWER_OFF;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_ack_answer; take |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("bus request not answered");
  property p_ack_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus answer longer than one cycle");
  property p_dat_byte; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_dat_byte: assert property (p_dat_byte)
    else $error("read data above byte not zero");
  property p_chan_write;
    !$stable(channel_select_o) && !$past(rst_i) |-> $past(ctl_wr, 2);
  endproperty
  a_chan_write: assert property (p_chan_write)
    else $error("channel changed without control write");
  property p_ref_high;
    high_reference_o == (channel_select_o == sac_pkg::CHANNEL_HIGH_REFERENCE);
  endproperty
  a_ref_high: assert property (p_ref_high)
    else $error("high reference select wrong");
  property p_ref_low;
    low_reference_o == (channel_select_o == sac_pkg::CHANNEL_LOW_REFERENCE);
  endproperty
  a_ref_low: assert property (p_ref_low)
    else $error("low reference select wrong");
  property p_off_power; off |-> power_down_o; endproperty
  a_off_power: assert property (p_off_power)
    else $error("power off code without power down");
  property p_off_idle; off [*3] |-> !converting_o; endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("converting while powered off");
  property p_stop_idle; stop_i [*3] |-> !converting_o; endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("converting in stop mode");
  property p_irq_cause;
    $rose(irq_o) |-> $past(converting_o) || $past(converting_o, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without conversion end");
  c_irq: cover property ($rose(irq_o));
  c_wake: cover property ($fell(power_down_o));
  c_done: cover property ($fell(converting_o));
endmodule : sac_control_sva

bind sac_control sac_control_sva u_sac_control_sva (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .stop_i(stop_i), .irq_o(irq_o), .channel_select_o(channel_select_o),
  .high_reference_o(high_reference_o), .low_reference_o(low_reference_o),
  .power_down_o(power_down_o), .converting_o(converting_o)
);
`default_nettype wire

// >>> sim/sac_control_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic stop = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [sac_pkg::ADDR_W-1:0] adr = 4'h0;
  logic [sac_pkg::DATA_W-1:0] wdat = 32'h00000000;
  logic [sac_pkg::DATA_W-1:0] rdat;
  logic [9:0] res;
  logic [9:0] trim = 10'h000;
  logic [4:0] chan;
  logic [7:0] rd;
  logic [15:0] v;
  logic ack, irq, osc, hiref, loref, pdn, conv;
  int fails = 0;
  int tests_run = 0;
  int n;
  always #25 clk_i = ~clk_i;
  sac_control dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .stop_i(stop), .irq_o(irq), .oscillator_clock_i(osc),
    .conv_result_i(res), .channel_select_o(chan),
    .high_reference_o(hiref), .low_reference_o(loref),
    .power_down_o(pdn), .converting_o(conv)
  );
  sac_converter_model model (
    .clk_i(clk_i), .trim_i(trim), .channel_select_i(chan),
    .high_reference_i(hiref), .low_reference_i(loref),
    .power_down_i(pdn), .oscillator_clock_o(osc), .conv_result_o(res)
  );
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      fails++;
      finish_test();
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask : bus
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, e);
  endtask : rdchk
  task automatic ctl(input logic [7:0] d);
    bus(1'b1, sac_pkg::OFS_STATUS_CONTROL, d);
  endtask : ctl
  task automatic cfg(input logic [7:0] d);
    bus(1'b1, sac_pkg::OFS_CLOCK_CONFIG, d);
  endtask : cfg
  task automatic res_chk(input logic [15:0] e);
    rdchk(sac_pkg::OFS_RESULT_HIGH, e[15:8]);
    rdchk(sac_pkg::OFS_RESULT_LOW, e[7:0]);
  endtask : res_chk
  task automatic wait_flag();
    n = 0;
    do begin
      bus(1'b0, sac_pkg::OFS_STATUS_CONTROL, 8'h00);
      n++;
    end while (rd[7] !== 1'b1 && n < 40);
    check({7'h00, rd[7]}, 8'h01);
  endtask : wait_flag
  task automatic wait_hi(input int s);
    n = 0;
    while (((s == 0) ? irq : conv) !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check({7'h00, n < 100}, 8'h01);
  endtask : wait_hi
  task automatic timed(input logic [7:0] c, input int lo, input int hi);
    cfg(c);
    ctl(8'h00);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (conv === 1'b1 && n < 600);
    check({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask : timed
  function automatic logic [9:0] expv(input logic [4:0] c);
    if (c == sac_pkg::CHANNEL_HIGH_REFERENCE) begin
      expv = 10'h3FF;
    end else if (c == sac_pkg::CHANNEL_LOW_REFERENCE) begin
      expv = 10'h000;
    end else begin
      expv = {c[2:0], 7'h4B} ^ trim;
    end
  endfunction : expv
  function automatic logic [15:0] lay(input logic [1:0] m, input logic [9:0] r);
    case (m)
      2'h0: lay = {8'h00, r[9:2]};
      2'h1: lay = {6'h00, r};
      2'h2: lay = {r, 6'h00};
      default: lay = {r ^ 10'h200, 6'h00};
    endcase
  endfunction : lay
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(sac_pkg::OFS_STATUS_CONTROL, 8'h1F);
    rdchk(sac_pkg::OFS_CLOCK_CONFIG, 8'h04);
    check({7'h00, pdn}, 8'h01);
    ctl(8'h9F);
    rdchk(sac_pkg::OFS_STATUS_CONTROL, 8'h1F);
    cfg(8'h13);
    rdchk(sac_pkg::OFS_CLOCK_CONFIG, 8'h10);
    bus(1'b1, 4'h2, 8'hFF);
    rdchk(4'h2, 8'h00);
    $display("test registers done");
    cfg(8'h14);
    ctl(8'h06);
    repeat (10) @(posedge clk_i);
    rdchk(sac_pkg::OFS_STATUS_CONTROL, 8'h06);
    wait_flag();
    bus(1'b0, sac_pkg::OFS_RESULT_LOW, 8'h00);
    repeat (40) @(posedge clk_i);
    check({7'h00, conv}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ctl(8'(i));
      wait_flag();
      res_chk(lay(2'h1, expv(5'(i))));
      rdchk(sac_pkg::OFS_STATUS_CONTROL, 8'(i));
    end
    ctl(8'h01);
    repeat (8) @(posedge clk_i);
    ctl(8'h02);
    repeat (8) @(posedge clk_i);
    rdchk(sac_pkg::OFS_STATUS_CONTROL, 8'h02);
    wait_flag();
    res_chk(lay(2'h1, expv(5'h02)));
    $display("test single conversions done");
    for (int m = 0; m < 4; m++) begin
      cfg(8'h10 | 8'(m << 2));
      ctl(8'h05);
      wait_flag();
      res_chk(lay(2'(m), expv(5'h05)));
    end
    cfg(8'h14);
    for (int r = 0; r < 2; r++) begin
      ctl(8'h1D + 8'(r));
      @(posedge clk_i);
      check({6'h00, hiref, loref}, 8'h02 >> r);
      wait_flag();
      res_chk(lay(2'h1, expv(5'h1D + 5'(r))));
    end
    $display("test layouts done");
    ctl(8'h43);
    wait_hi(0);
    rdchk(sac_pkg::OFS_STATUS_CONTROL, 8'h43);
    v = lay(2'h1, expv(5'h03));
    rdchk(sac_pkg::OFS_RESULT_LOW, v[7:0]);
    check({7'h00, irq}, 8'h00);
    ctl(8'h43);
    wait_hi(0);
    ctl(8'h47);
    check({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    ctl(8'h22);
    repeat (40) @(posedge clk_i);
    res_chk(lay(2'h1, expv(5'h02)));
    trim <= 10'h003;
    repeat (40) @(posedge clk_i);
    v = lay(2'h1, expv(5'h02));
    rdchk(sac_pkg::OFS_RESULT_HIGH, v[15:8]);
    trim <= 10'h0F0;
    repeat (40) @(posedge clk_i);
    rdchk(sac_pkg::OFS_RESULT_LOW, v[7:0]);
    repeat (40) @(posedge clk_i);
    res_chk(lay(2'h1, expv(5'h02)));
    stop <= 1'b1;
    repeat (20) @(posedge clk_i);
    check({7'h00, conv}, 8'h00);
    stop <= 1'b0;
    wait_hi(1);
    ctl(8'h05);
    ce <= 1'b0;
    repeat (40) @(posedge clk_i);
    check({7'h00, conv}, 8'h01);
    ce <= 1'b1;
    repeat (20) @(posedge clk_i);
    check({7'h00, conv}, 8'h00);
    ctl(8'h1F);
    repeat (3) @(posedge clk_i);
    check({6'h00, pdn, conv}, 8'h02);
    $display("test continuous and stop done");
    for (int i = 0; i < 6; i++) begin
      n = (i < 5) ? i : 7;
      n = (n > 3) ? 16 : (1 << n);
      timed(8'h14 | 8'((i < 5 ? i : 7) << 5), 16 * n, 17 * n + 2);
    end
    timed(8'h04, 40, 64);
    $display("test clock divider done");
    finish_test();
  end
endmodule : sac_control_tb
`default_nettype wire

// >>> sim/sac_converter_model.sv
// Behavioural model of the analog converter and input multiplexer
`timescale 1ns/1ps
`default_nettype none
module sac_converter_model (
  // Clock and trim
  input wire logic clk_i,
  input wire logic [9:0] trim_i,
  // Converter controls
  input wire logic [4:0] channel_select_i,
  input wire logic high_reference_i,
  input wire logic low_reference_i,
  input wire logic power_down_i,
  // Converter outputs
  output logic oscillator_clock_o,
  output logic [9:0] conv_result_o
);
  logic osc = 1'b0;
  logic [9:0] sample = 10'h155;
  assign oscillator_clock_o = osc;
  assign conv_result_o = sample;
  // Free running oscillator
  always #70 osc = ~osc;
  always @(posedge clk_i) begin
    if (power_down_i || (channel_select_i[4:3] != 2'h0
        && !high_reference_i && !low_reference_i)) begin
      sample <= ~sample;
    end else if (high_reference_i) begin
      sample <= 10'h3FF;
    end else if (low_reference_i) begin
      sample <= 10'h000;
    end else begin
      sample <= {channel_select_i[2:0], 7'h4B} ^ trim_i;
    end
  end
endmodule : sac_converter_model
`default_nettype wire
